// [hw/sicr_pkg.sv]
// Shared constants, state codes and pin bundles for the serial interrupt
// and clock request agent.
// Assumes one clock domain, the bus clock of the serial interrupt link.
package sicr_pkg;

   // ----------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------
   localparam int unsigned FRAME_COUNT     = 16;      // Interrupt frames this agent drives
   localparam logic [4:0]  FRAME_FIRST     = 5'h01;   // First frame with a level in it
   localparam logic [4:0]  FRAME_LAST      = 5'h10;   // Last frame with a level in it
   localparam logic [4:0]  FRAME_SAT       = 5'h1f;   // Frame counter stops here
   localparam logic [1:0]  PH_SAMPLE       = 2'h0;    // Sample phase of a frame
   localparam logic [1:0]  PH_RECOVER      = 2'h1;    // Recovery phase of a frame
   localparam logic [1:0]  PH_TURN         = 2'h2;    // Turn-around phase of a frame
   localparam logic [1:0]  PH_AFTER_START  = 2'h2;    // Clock after the start pulse high is a turn-around

   // ----------------------------------------------------------------
   // Stop frame widths
   // ----------------------------------------------------------------
   localparam logic [2:0]  STOP_DETECT_W   = 3'h1;    // Lows seen before this one flag a stop
   localparam logic [2:0]  STOP_QUIET_W    = 3'h2;    // Width that selects quiet mode
   localparam logic [2:0]  LOW_SAT         = 3'h7;    // Low run counter stops here

   // ----------------------------------------------------------------
   // Clock request timing, in bus clocks
   // ----------------------------------------------------------------
   localparam logic [1:0]  CLKRUN_HIGH_MIN = 2'h2;    // Line high this long before a request
   localparam logic [1:0]  CLKRUN_HOLD     = 2'h2;    // Edges the request is held low
   localparam int unsigned LATENCY_MAX_CLK = 96;      // Worst update latency, 32 frames

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_DELIVERED   = 16'hffff; // Levels assumed idle high
   localparam logic        RST_QUIET       = 1'b0;     // Continuous mode after reset

   // Serial interrupt cycle states
   typedef enum logic [2:0] {
      SICR_IDLE    = 3'h0,
      SICR_START   = 3'h1,
      SICR_DATA    = 3'h2,
      SICR_STOP    = 3'h3,
      SICR_RECOVER = 3'h4
   } sicr_state_t;

   // Open-drain or three-state pin drive bundle
   typedef struct packed {
      logic drive_val;                                 // Level driven while enabled
      logic drive_en;                                  // High while the pin is driven
   } sicr_pin_t;

   localparam sicr_pin_t PIN_RELEASE = '{drive_val: 1'b0, drive_en: 1'b0};
   localparam sicr_pin_t PIN_LOW     = '{drive_val: 1'b0, drive_en: 1'b1};
   localparam sicr_pin_t PIN_HIGH    = '{drive_val: 1'b1, drive_en: 1'b1};

endpackage

// [hw/sicr_agent.sv]
// Peripheral agent for the serialized interrupt line and the clock request line.
// Assumes all inputs but arst_n are synchronous to sys_clk, the bus clock, and that the
// bench resolves both pins from the drive bundles (released pins pull high).
//
// Operation
// (RULE1) Only the host begins stop frames
// (RULE2) Two-clock stop selects quiet mode next
// (RULE3) Three-clock stop: continuous, host-only start
// (RULE4) Level update reaches host within 96 clocks
// (RULE5) Host delays end-of-interrupt by cycle latency
// (RULE6) Drive and sample only on rising edges
// (RULE7) Reset releases line, selects continuous mode
// (RULE8) Host runs first cycle after reset
// (RULE9) Host goes continuous before configuration change
// (RULE10) Enable low disables interrupts and clock requests
// (RULE11) Request line high means clock stopped
// (RULE12) Change or DMA request restarts stopped clock
// (RULE13) Hold request low for two edges
// (RULE14) Never drive request while resource holds low
// (RULE15) Request only after two high clocks
// (RULE16) Trigger is level change or DMA request
// (RULE17) Keep requesting until trigger is delivered
// (RULE18) Request clock before driving a start
// (RULE19) DMA request while stopped requests clock
// (RULE20) Request line is input, pulled low only
// (RULE21) Quiet start: one low clock, never high
// (RULE22) Frames: sample low, recover high, turn around
// (RULE23) Sample of frame N at 3N-1 clocks
// (RULE24) Mode changes only during a stop frame
// (RULE25) Count stop low width, store next mode
`timescale 1ns/100ps

module sicr_agent
   import sicr_pkg::*;
(
   input  wire logic          sys_clk,                    // Bus clock, 100 MHz
   input  wire logic          arst_n,                     // Bus reset, async, active low
   input  wire logic          serial_int_and_clock_request_enable, // Enable bit
   input  wire logic [15:0]   irq_level,                  // Internal levels, bit N-1 -> frame N
   input  wire logic          dma_req,                    // Internal DMA request level
   input  wire logic          ser_irq_in,                 // Serial interrupt line level
   input  wire logic          clkrun_n_in,                // Clock request line level
   output sicr_pkg::sicr_pin_t ser_irq_drv,               // Serial interrupt pin drive
   output sicr_pkg::sicr_pin_t clkrun_drv,                // Clock request pin drive
   output logic               quiet_mode,                 // Mode learned from last stop
   output logic               clock_request_pending       // A trigger awaits delivery
);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic        rst_meta;                                 // First stage, read by rst_n only
   logic        rst_n;                                    // Released reset for the block

   // Reset enters at once and leaves two edges later
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   sicr_state_t state;                                    // Cycle tracker state
   sicr_state_t next_state;                               // Its next value
   logic [1:0]  phase;                                    // Phase within a frame
   logic [1:0]  next_phase;                               // Its next value
   logic [4:0]  frame;                                    // Frame number, 0 before first
   logic [4:0]  next_frame;                               // Its next value
   logic [2:0]  low_run;                                  // Consecutive low clocks seen
   logic        drove_low;                                // Sample phase was driven low
   logic [15:0] delivered;                                // Levels last sent to the host
   logic [15:0] level_diff;                               // Levels not yet sent
   logic        irq_pend;                                 // Some level awaits a frame
   logic        clk_pend;                                 // Some trigger wants the clock
   logic        start_ok;                                 // Begin a quiet start this clock
   logic        sample_slot;                              // Next clock is a sample phase
   logic [3:0]  slot_idx;                                 // Level index for that sample
   logic [1:0]  high_run;                                 // Clocks the request line stayed high
   logic [1:0]  hold_cnt;                                 // Edges seen while requesting
   logic        enable;                                   // Short name for the enable input

   assign enable = serial_int_and_clock_request_enable;

   // ----------------------------------------------------------------
   // Trigger detection
   // ----------------------------------------------------------------
   // Level-based compare instead of edge capture: a change made while the
   // clock stands still is still seen at the first edge after restart.
   assign level_diff = irq_level ^ delivered;             // RULE16
   assign irq_pend   = |level_diff;                       // RULE16
   assign clk_pend   = enable && (irq_pend || dma_req);   // RULE19

   // Quiet start needs an idle line, quiet mode and a clock the resource runs;
   // our own pull on the request line does not mean the clock is back yet
   assign start_ok = (state == SICR_IDLE) && enable && quiet_mode && ser_irq_in
                     && irq_pend && !clkrun_n_in && !clkrun_drv.drive_en;  // RULE18

   // Level index of the sample phase coming next
   assign slot_idx    = 4'(next_frame - FRAME_FIRST);
   assign sample_slot = (state == SICR_DATA) && (next_state == SICR_DATA)
                        && (next_phase == PH_SAMPLE)
                        && (next_frame >= FRAME_FIRST) && (next_frame <= FRAME_LAST);

   // ----------------------------------------------------------------
   // Cycle tracker
   // ----------------------------------------------------------------
   // Next state, phase and frame from the line level
   always_comb begin
      next_state = state;
      next_phase = phase;
      next_frame = frame;
      unique case (state)
         SICR_IDLE: begin
            // Host start or our own start leads into the start pulse
            if (!ser_irq_in || start_ok) begin
               next_state = SICR_START;
            end
         end
         SICR_START: begin
            // Rising edge of the start pulse opens frame counting
            if (ser_irq_in && (low_run != 3'h0)) begin
               next_state = SICR_DATA;
               next_phase = PH_AFTER_START;               // RULE23
               next_frame = 5'h00;
            end
         end
         SICR_DATA: begin
            // Frame lows last one clock; a second low is the host's stop
            if (!ser_irq_in && (low_run >= STOP_DETECT_W)) begin
               next_state = SICR_STOP;                    // RULE1
            end else if (phase == PH_TURN) begin
               next_phase = PH_SAMPLE;                    // RULE23
               next_frame = (frame == FRAME_SAT) ? frame : 5'(frame + 5'h01);
            end else begin
               next_phase = 2'(phase + 2'h1);
            end
         end
         SICR_STOP: begin
            // Stop pulse ends on the first high clock
            if (ser_irq_in) begin
               next_state = SICR_RECOVER;
            end
         end
         SICR_RECOVER: begin
            // One clock of gap so no start before the second clock after stop
            next_state = ser_irq_in ? SICR_IDLE : SICR_START;  // RULE2
         end
         default: begin
            next_state = SICR_IDLE;
         end
      endcase
      if (!enable) begin
         next_state = SICR_IDLE;                          // RULE10
      end
   end

   // State registers follow the line on each rising edge
   always_ff @(posedge sys_clk or negedge rst_n) begin    // RULE6
      if (!rst_n) begin
         state <= SICR_IDLE;
         phase <= PH_SAMPLE;
         frame <= 5'h00;
      end else begin
         state <= next_state;
         phase <= next_phase;
         frame <= next_frame;
      end
   end

   // Run of consecutive low clocks, measures start and stop widths
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_run <= 3'h0;
      end else if (ser_irq_in) begin
         low_run <= 3'h0;
      end else if (low_run != LOW_SAT) begin
         low_run <= 3'(low_run + 3'h1);                   // RULE25
      end
   end

   // Mode is taken only as the stop pulse ends
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         quiet_mode <= RST_QUIET;                         // RULE7
      end else if ((state == SICR_STOP) && ser_irq_in) begin
         quiet_mode <= (low_run == STOP_QUIET_W);         // RULE24
      end
   end

   // ----------------------------------------------------------------
   // Serial interrupt pin drive
   // ----------------------------------------------------------------
   // Registered drive: decisions are made one clock ahead of the phase
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ser_irq_drv <= PIN_RELEASE;                      // RULE7
         drove_low   <= 1'b0;
      end else if (!enable) begin
         ser_irq_drv <= PIN_RELEASE;                      // RULE10
         drove_low   <= 1'b0;
      end else if (start_ok) begin
         // One low clock, the host holds the pulse from then on
         ser_irq_drv <= PIN_LOW;                          // RULE21
         drove_low   <= 1'b0;
      end else if (sample_slot && !irq_level[slot_idx]) begin
         ser_irq_drv <= PIN_LOW;                          // RULE22
         drove_low   <= 1'b1;
      end else if (drove_low) begin
         // Recovery drives high only after our own low sample
         ser_irq_drv <= PIN_HIGH;                         // RULE22
         drove_low   <= 1'b0;
      end else begin
         ser_irq_drv <= PIN_RELEASE;                      // RULE22
         drove_low   <= 1'b0;
      end
   end

   // Record what each sample slot sent, one flop per level
   genvar gi;
   generate
      for (gi = 0; gi < FRAME_COUNT; gi++) begin : g_sent
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               delivered[gi] <= RST_DELIVERED[gi];
            end else if (enable && sample_slot && (slot_idx == 4'(gi))) begin
               delivered[gi] <= irq_level[gi];            // RULE4
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Clock request
   // ----------------------------------------------------------------
   // High history of the request line; low means the clock runs
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         high_run <= 2'h0;
      end else if (!clkrun_n_in) begin
         high_run <= 2'h0;                                // RULE11
      end else if (high_run != CLKRUN_HIGH_MIN) begin
         high_run <= 2'(high_run + 2'h1);
      end
   end

   // Pull low only, hold two edges, repeat while a trigger is pending
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         clkrun_drv <= PIN_RELEASE;
         hold_cnt   <= 2'h0;
      end else if (!enable) begin
         clkrun_drv <= PIN_RELEASE;                       // RULE10
         hold_cnt   <= 2'h0;
      end else if (clkrun_drv.drive_en) begin
         if (hold_cnt == 2'(CLKRUN_HOLD - 2'h1)) begin
            clkrun_drv <= PIN_RELEASE;                    // RULE13
            hold_cnt   <= 2'h0;
         end else begin
            hold_cnt   <= 2'(hold_cnt + 2'h1);
         end
      end else if (clk_pend && clkrun_n_in && (high_run == CLKRUN_HIGH_MIN)) begin
         // Line high long enough, and nobody else holds it low
         clkrun_drv <= PIN_LOW;                           // RULE12 RULE14 RULE15 RULE17 RULE20
         hold_cnt   <= 2'h0;
      end
   end

   // Pending flag for the outside world
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         clock_request_pending <= 1'b0;
      end else begin
         clock_request_pending <= clk_pend;               // RULE17
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_start_drive;
      ser_irq_drv.drive_en && !ser_irq_drv.drive_val;
   endsequence

   sequence s_recover_then_release;
      (ser_irq_drv.drive_en && ser_irq_drv.drive_val) ##1 !ser_irq_drv.drive_en;
   endsequence

   sequence s_hold_then_release;
      clkrun_drv.drive_en [*2] ##1 !clkrun_drv.drive_en;
   endsequence

   chk_reset_line_free: assert property (disable iff (1'b0)   // RULE7
      !rst_n |-> !ser_irq_drv.drive_en && !clkrun_drv.drive_en)
      else $error("line driven during reset");

   chk_start_one_low: assert property (                       // RULE21
      start_ok |=> s_start_drive ##1 !ser_irq_drv.drive_en)
      else $error("quiet start not a single low clock");

   chk_start_quiet_only: assert property (                    // RULE3
      (state == SICR_START && $past(state) == SICR_IDLE && ser_irq_drv.drive_en)
      |-> $past(quiet_mode) && !$past(clkrun_n_in))
      else $error("start begun outside quiet mode or without clock");

   chk_sample_recovery: assert property (                     // RULE22
      (state == SICR_DATA && ser_irq_drv.drive_en && !ser_irq_drv.drive_val)
      |=> s_recover_then_release)
      else $error("sample low not followed by recovery high");

   chk_stop_mode_learn: assert property (                     // RULE25
      (state == SICR_STOP && ser_irq_in) |=> quiet_mode == ($past(low_run) == 3'h2))
      else $error("mode does not match stop width");

   chk_mode_only_stop: assert property (                      // RULE24
      $changed(quiet_mode) |-> $past(state) == SICR_STOP)
      else $error("mode changed outside a stop frame");

   chk_clkrun_hold: assert property (                         // RULE13
      $rose(clkrun_drv.drive_en) |-> s_hold_then_release)
      else $error("clock request not held two edges");

   chk_clkrun_precond: assert property (                      // RULE15
      $rose(clkrun_drv.drive_en) |-> $past(clkrun_n_in) && $past(clkrun_n_in, 2))
      else $error("clock request without two high clocks");

   chk_clkrun_pull_low: assert property (                     // RULE20
      clkrun_drv.drive_en |-> !clkrun_drv.drive_val)
      else $error("clock request line driven high");

   chk_disabled_quiet: assert property (                      // RULE10
      !enable |=> !clkrun_drv.drive_en && !ser_irq_drv.drive_en)
      else $error("pin driven while disabled");

   chk_clkrun_request: assert property (                      // RULE12
      (clk_pend && clkrun_n_in && high_run == 2'h2 && !clkrun_drv.drive_en)
      |=> clkrun_drv.drive_en)
      else $error("stopped clock not requested");

endmodule // sicr_agent

// [testbench/sicr_host_model.sv]
// Host side model: serial interrupt controller plus the central clock resource.
// Assumes the bench resolves both lines with pull-ups and feeds them back here.
`timescale 1ns/100ps

module sicr_host_model
   import sicr_pkg::*;
(
   input  wire logic           sys_clk,       // Bus clock
   input  wire logic           ser_irq_line,  // Resolved serial interrupt line
   input  wire logic           clkrun_line,   // Resolved clock request line
   output sicr_pkg::sicr_pin_t host_drv,      // Controller drive of the serial line
   output sicr_pkg::sicr_pin_t gen_drv        // Clock resource drive of the request line
);
   import sicr_pkg::*;

   logic    clock_running = 1'b0;   // Resource holds the request line low
   logic    auto_restart  = 1'b0;   // Restart when a device pulls the line
   logic    saw_dev_start = 1'b0;   // Last device-start cycle was opened by the device
   // Moment the last frame was sampled; the bench checks update latency against this
   realtime t_last        = 0.0;

   initial host_drv = PIN_RELEASE;

   // Low means running, released means stopped
   assign gen_drv = clock_running ? PIN_LOW : PIN_RELEASE;

   // Restart only when told to, so a scenario can leave requests unanswered
   always @(posedge sys_clk) begin
      if (auto_restart && !clkrun_line) begin
         clock_running <= 1'b1;
      end
   end

   task automatic set_clock(input logic run, input logic autor);
      clock_running <= run;
      auto_restart  <= autor;
   endtask

   // One full cycle: start, 16 frames, stop of the given width
   task automatic run_cycle(input logic dev_start, input int stop_w, output logic [15:0] got);
      int k;
      got = 'x;
      k = 0;
      if (dev_start) begin
         while (ser_irq_line !== 1'b0 && k < 60) begin
            @(posedge sys_clk);
            k++;
         end
         saw_dev_start = (ser_irq_line === 1'b0);
         host_drv <= PIN_LOW;
         repeat (3) @(posedge sys_clk);
      end else begin
         @(posedge sys_clk);
         host_drv <= PIN_LOW;
         repeat (4) @(posedge sys_clk);
      end
      host_drv <= PIN_HIGH;
      for (k = 1; k <= 54 + stop_w; k++) begin
         @(posedge sys_clk);
         if (k == 1) host_drv <= PIN_RELEASE;
         if (k % 3 == 0 && k <= 48) got[k/3-1] = ser_irq_line;
         if (k == 48) t_last = $realtime;
         if (k == 53) host_drv <= PIN_LOW;
         if (k == 53 + stop_w) host_drv <= PIN_HIGH;
         if (k == 54 + stop_w) host_drv <= PIN_RELEASE;
      end
   endtask
endmodule // sicr_host_model

// [testbench/serial_irq_stop_and_clock_run_tb.sv]
// Self-checking bench for the serial interrupt and clock request agent.
// Assumes sicr_host_model as the far side; both lines are pulled high.
`timescale 1ns/100ps

module serial_irq_stop_and_clock_run_tb;
   import sicr_pkg::*;

   logic        sys_clk = 1'b0;     // 100 MHz bus clock
   logic        arst_n  = 1'b0;     // Bus reset
   logic        en      = 1'b1;     // Enable bit
   logic [15:0] irq     = 16'hffff; // Internal levels
   logic        dma     = 1'b0;     // Internal DMA request
   sicr_pin_t   ser_drv, clk_drv, host_drv, gen_drv;
   logic        quiet, pending, ser_line, clk_line, early, any_drv;
   logic [15:0] got;
   int          fails = 0;
   int          n_checks = 0;
   int          gap, width;
   realtime     t0;

   always #5 sys_clk = ~sys_clk;

   // Wired-AND with pull-ups on both lines
   assign ser_line = ((ser_drv.drive_en && !ser_drv.drive_val) ||
                      (host_drv.drive_en && !host_drv.drive_val)) ? 1'b0 : 1'b1;
   assign clk_line = ((clk_drv.drive_en && !clk_drv.drive_val) ||
                      (gen_drv.drive_en && !gen_drv.drive_val)) ? 1'b0 : 1'b1;

   sicr_agent dut (.sys_clk(sys_clk), .arst_n(arst_n),
      .serial_int_and_clock_request_enable(en), .irq_level(irq), .dma_req(dma),
      .ser_irq_in(ser_line), .clkrun_n_in(clk_line), .ser_irq_drv(ser_drv),
      .clkrun_drv(clk_drv), .quiet_mode(quiet), .clock_request_pending(pending));

   sicr_host_model host (.sys_clk(sys_clk), .ser_irq_line(ser_line),
      .clkrun_line(clk_line), .host_drv(host_drv), .gen_drv(gen_drv));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // Any agent drive at all over n clocks
   task automatic watch(input int n);
      any_drv = 1'b0;
      repeat (n) begin
         @(posedge sys_clk);
         any_drv |= (ser_drv.drive_en !== 1'b0) || (clk_drv.drive_en !== 1'b0);
      end
   endtask

   // Clocks until a request pulse, and its width; notes serial drive before it
   task automatic clk_pulse();
      gap = 0;
      width = 0;
      early = 1'b0;
      while (clk_drv.drive_en !== 1'b1 && gap < 40) begin
         early |= (ser_drv.drive_en === 1'b1);
         gap++;
         @(posedge sys_clk);
      end
      while (clk_drv.drive_en === 1'b1 && width < 40) begin
         chk("request level", 1'b0, clk_drv.drive_val);
         width++;
         @(posedge sys_clk);
      end
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      repeat (8) begin
         @(negedge sys_clk);
         chk("reset drive", 16'h0, {ser_drv.drive_en, clk_drv.drive_en});
      end
      @(posedge sys_clk);
      arst_n <= 1'b1;
      tick(3);
      chk("reset mode", 16'h0, quiet);
      $display("test reset done");
   endtask

   task automatic t_continuous();
      host.set_clock(1'b1, 1'b0);
      irq <= 16'h5a3c;
      tick(3);
      host.run_cycle(1'b0, 3, got);
      chk("frames", 16'h5a3c, got);
      tick(2);
      chk("mode after 3", 16'h0, quiet);
      irq <= 16'h5a3d;
      watch(30);
      chk("continuous start", 16'h0, any_drv);
      $display("test continuous done");
   endtask

   task automatic t_quiet();
      host.run_cycle(1'b0, 2, got);
      chk("held change", 16'h5a3d, got);
      tick(2);
      chk("mode after 2", 16'h1, quiet);
      irq <= 16'h5a3f;
      t0 = $realtime;
      host.run_cycle(1'b1, 2, got);
      chk("own start frames", 16'h5a3f, got);
      chk("own start seen", 16'h1, host.saw_dev_start);
      chk("latency", 16'h1, (host.t_last - t0) <= 960.0);
      $display("test quiet done");
   endtask

   task automatic t_clkrun();
      host.set_clock(1'b0, 1'b0);
      tick(4);
      irq <= 16'h5a1f;
      clk_pulse();
      chk("request seen", 16'h1, gap <= 4);
      chk("request width", 16'h2, width[15:0]);
      chk("serial before request", 16'h0, early);
      chk("pending set", 16'h1, pending);
      host.set_clock(1'b0, 1'b1);
      clk_pulse();
      chk("repeat spacing", 16'h1, gap >= 2 && gap <= 6);
      host.run_cycle(1'b1, 2, got);
      chk("delivered", 16'h5a1f, got);
      chk("start after clock", 16'h1, host.saw_dev_start);
      tick(3);
      chk("pending cleared", 16'h0, pending);
      $display("test clock request done");
   endtask

   task automatic t_dma();
      host.set_clock(1'b1, 1'b0);
      dma <= 1'b1;
      watch(20);
      chk("held low", 16'h0, any_drv);
      host.set_clock(1'b0, 1'b0);
      clk_pulse();
      chk("dma spacing", 16'h1, gap >= 2 && gap <= 6);
      chk("dma width", 16'h2, width[15:0]);
      dma <= 1'b0;
      host.set_clock(1'b1, 1'b0);
      tick(4);
      $display("test dma done");
   endtask

   task automatic t_disable();
      host.run_cycle(1'b0, 3, got);
      chk("before change", 16'h5a1f, got);
      tick(2);
      chk("idle before change", 16'h0, quiet);
      en <= 1'b0;
      host.set_clock(1'b0, 1'b0);
      tick(2);
      irq <= 16'h0000;
      dma <= 1'b1;
      watch(30);
      chk("disabled drive", 16'h0, any_drv);
      $display("test disable done");
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      t_reset();
      t_continuous();
      t_quiet();
      t_clkrun();
      t_dma();
      t_disable();
      tally_and_finish();
   end

   // Whole run is well under 1000 clocks
   initial begin
      #100000;
      fails++;
      tally_and_finish();
   end
endmodule // serial_irq_stop_and_clock_run_tb
